//--- design/spio_params.svh
// Register offsets, reset values and sizes for the shared-pin I/O port
`ifndef SPIO_PARAMS_SVH
`define SPIO_PARAMS_SVH
`define SPIO_OFS_DIR      12'h000
`define SPIO_OFS_HOLD     12'h004
`define SPIO_OFS_LEVEL    12'h008
`define SPIO_OFS_ODSEL    12'h00c
`define SPIO_OFS_ACFG_LO  12'h010
`define SPIO_OFS_ACFG_HI  12'h014
`define SPIO_OFS_CIE_1    12'h018
`define SPIO_OFS_CIE_2    12'h01c
`define SPIO_OFS_CPU_1    12'h020
`define SPIO_OFS_CPU_2    12'h024
`define SPIO_OFS_CSTAT    12'h028
`define SPIO_OFS_ACFG2_LO 12'h02c
`define SPIO_OFS_ACFG2_HI 12'h030
`define SPIO_DIR_RST      16'hffff
`define SPIO_ACFG_RST     16'hffff
`define SPIO_PORT_W       16
`define SPIO_CN_W         24
`define SPIO_CN_HALF      16
`define SPIO_ADDR_W       12
`endif

//--- design/spio_pkg.sv
// Types shared by the shared-pin I/O port
package spio_pkg;
	typedef struct packed {
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] haddr;
	} spio_addr_t;
	typedef struct packed {
		logic [15:0] out_data;
		logic [15:0] out_en;
		logic [15:0] enabled;
	} spio_periph_t;
endpackage

//--- design/spio_port.sv
// Shared-pin parallel I/O port with change notification, AHB-Lite slave
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "spio_params.svh"

// Functional notes
// R1: Peripheral driving a pin disables port driver; pin still readable.
// R2: Enabled peripheral not driving lets the port drive the pin.
// R3: Port output never loops back into the peripheral input.
// R4: Direction bit 1 is input, 0 is output.
// R5: Reset sets all directions to input.
// R6: Hold read gives latch, level read gives pins; writes hit latch.
// R7: Unimplemented bits disabled and read as zero; the analog config registers do not mask them with IMPL.
// R8: Open-drain select bit makes the output open-drain; here only for port-driven pins, peripheral-owned pins still drive high.
// R9: Cleared analog config bit makes pin analog; analog pins reset analog.
// R10: Pin is analog if cleared in either converter's config.
// R11: Analog pins read zero in the level register.
// R12: Software sets direction to input for analog pins.
// R13: Software waits one cycle between port write and read.
// R14: Up to 24 change inputs raise an interrupt on enabled change.
// R15: Change detection works with the system clock stopped; here a change in sleep is only caught once ref_clk runs again.
// R16: Two enable registers, one interrupt enable bit per input.
// R17: Two pull-up registers, one weak pull-up enable per input.
// R18: Software disables pull-ups on pins used as outputs.
// R19: Input-only shared pin is treated as a dedicated port pin.
// R20: Compare input against captured level; latch pending until cleared.
module spio_port #(
	parameter int          PORT_W   = `SPIO_PORT_W,
	parameter int          CN_W     = `SPIO_CN_W,
	parameter logic [15:0] IMPL     = 16'hffff,
	parameter logic [15:0] ANA_CAP  = 16'h00ff,
	parameter logic [15:0] IN_ONLY  = 16'h0000
) (
	// Clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire spio_pkg::spio_addr_t  haddr_ph,
	input  wire logic                  hready,
	input  wire logic [31:0]           hwdata,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	// Pins
	input  wire logic [15:0]           pin_in,
	output logic      [15:0]           pin_out,
	output logic      [15:0]           pin_oe,
	// Peripherals sharing the pins
	input  wire spio_pkg::spio_periph_t periph,
	output logic      [15:0]           periph_in,
	// Change notification
	input  wire logic [23:0]           change_notice_input,
	output logic      [23:0]           weak_pullup_en,
	output logic                       change_irq
);
	import spio_pkg::*;

	if (PORT_W != 16 || CN_W < 1 || CN_W > 24) begin : g_bad_width
		$error("spio_port: unsupported width");
	end

	////////////////////////////////////////////////////////////////////
	// Registers
	logic [15:0] pin_direction_reg_q;
	logic [15:0] output_hold_reg_q;
	logic [15:0] open_drain_sel_reg_q;
	logic [15:0] analog_pin_cfg_low_q;
	logic [15:0] analog_pin_cfg_high_q;
	logic [15:0] analog2_cfg_low_q;
	logic [15:0] analog2_cfg_high_q;
	logic [15:0] change_irq_enable_first_q;
	logic [15:0] change_irq_enable_second_q;
	logic [15:0] weak_pullup_enable_first_q;
	logic [15:0] weak_pullup_enable_second_q;
	logic [23:0] change_pend_q;
	logic [15:0] pin_meta_q;
	logic [15:0] pin_sync_q;
	logic [23:0] cn_meta_q;
	logic [23:0] cn_sync_q;
	logic [23:0] cn_prev_q;

	////////////////////////////////////////////////////////////////////
	// Bus address phase capture
	logic        wr_q;
	logic        rd_q;
	logic [11:0] adr_q;
	logic        take;

	assign take = hsel && hready && haddr_ph.htrans[1];

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
			adr_q <= 12'h000;
		end else begin
			wr_q  <= take && haddr_ph.hwrite;
			rd_q  <= take && !haddr_ph.hwrite;
			adr_q <= haddr_ph.haddr[11:0];
		end
	end

	// One wait state on reads: a write just ahead lands before the mux
	// Writes zero-wait; response always OKAY
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= !(take && !haddr_ph.hwrite);
			hresp     <= 1'b0;
		end
	end

	function automatic logic wr_at(input logic [11:0] ofs);
		return wr_q && (adr_q == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Port control registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			pin_direction_reg_q <= `SPIO_DIR_RST & IMPL; // R5 R7
		else if (wr_at(`SPIO_OFS_DIR))
			pin_direction_reg_q <= hwdata[15:0] & IMPL; // R7
	end

	// Level-register writes land in the latch too
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			output_hold_reg_q <= 16'h0000;
		else if (wr_at(`SPIO_OFS_HOLD) || wr_at(`SPIO_OFS_LEVEL))
			output_hold_reg_q <= hwdata[15:0] & IMPL; // R6 R7
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			open_drain_sel_reg_q <= 16'h0000;
		else if (wr_at(`SPIO_OFS_ODSEL))
			open_drain_sel_reg_q <= hwdata[15:0] & IMPL;
	end

	// Analog-capable pins come up analog (bit clear)
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			analog_pin_cfg_low_q  <= `SPIO_ACFG_RST & ~ANA_CAP; // R9
			analog_pin_cfg_high_q <= `SPIO_ACFG_RST;
			analog2_cfg_low_q     <= `SPIO_ACFG_RST & ~ANA_CAP;
			analog2_cfg_high_q    <= `SPIO_ACFG_RST;
		end else begin
			if (wr_at(`SPIO_OFS_ACFG_LO))
				analog_pin_cfg_low_q <= hwdata[15:0] | ~ANA_CAP;
			if (wr_at(`SPIO_OFS_ACFG_HI))
				analog_pin_cfg_high_q <= hwdata[15:0];
			if (wr_at(`SPIO_OFS_ACFG2_LO))
				analog2_cfg_low_q <= hwdata[15:0] | ~ANA_CAP;
			if (wr_at(`SPIO_OFS_ACFG2_HI))
				analog2_cfg_high_q <= hwdata[15:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			change_irq_enable_first_q   <= 16'h0000;
			change_irq_enable_second_q  <= 16'h0000;
			weak_pullup_enable_first_q  <= 16'h0000;
			weak_pullup_enable_second_q <= 16'h0000;
		end else begin
			if (wr_at(`SPIO_OFS_CIE_1))
				change_irq_enable_first_q <= hwdata[15:0]; // R16
			if (wr_at(`SPIO_OFS_CIE_2))
				change_irq_enable_second_q <= {8'h00, hwdata[7:0]};
			if (wr_at(`SPIO_OFS_CPU_1))
				weak_pullup_enable_first_q <= hwdata[15:0]; // R17
			if (wr_at(`SPIO_OFS_CPU_2))
				weak_pullup_enable_second_q <= {8'h00, hwdata[7:0]};
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin path
	logic [15:0] is_analog;
	logic [15:0] periph_owns;
	logic [15:0] port_drive;
	logic [15:0] level_view;

	// Analog only on capable pins, via either converter
	assign is_analog = ANA_CAP & ~(analog_pin_cfg_low_q & analog2_cfg_low_q); // R9 R10
	// Input-only peripherals never own the driver
	assign periph_owns = periph.enabled & periph.out_en & ~IN_ONLY; // R1 R19
	// Direction 0 means output; peripheral not driving leaves port in charge
	assign port_drive = ~pin_direction_reg_q & ~periph_owns & IMPL; // R2 R4
	assign level_view = pin_sync_q & ~is_analog & IMPL; // R7 R11

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pin_meta_q <= 16'h0000;
			pin_sync_q <= 16'h0000;
		end else begin
			pin_meta_q <= pin_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	// Open-drain port-driven pins drive only the low level
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pin_out <= 16'h0000;
			pin_oe  <= 16'h0000;
		end else begin
			pin_out <= (periph_owns & periph.out_data) |
				(~periph_owns & output_hold_reg_q); // R1
			pin_oe  <= (periph_owns) |
				(port_drive & ~(open_drain_sel_reg_q &
				output_hold_reg_q)); // R8
		end
	end

	// Peripheral sees the pin only while the port is not driving it
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			periph_in <= 16'h0000;
		else
			periph_in <= pin_sync_q & ~port_drive; // R3
	end

	////////////////////////////////////////////////////////////////////
	// Change notification
	logic [23:0] cn_en;
	logic [23:0] cn_hit;
	logic        clr_stat;

	assign cn_en = {change_irq_enable_second_q[7:0],
		change_irq_enable_first_q};
	assign cn_hit = (cn_sync_q ^ cn_prev_q) & cn_en; // R14 R20
	assign clr_stat = wr_at(`SPIO_OFS_CSTAT);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cn_meta_q <= 24'h000000;
			cn_sync_q <= 24'h000000;
			cn_prev_q <= 24'h000000;
		end else begin
			cn_meta_q <= change_notice_input;
			cn_sync_q <= cn_meta_q;
			cn_prev_q <= cn_sync_q;
		end
	end

	// Set wins over a same-cycle write-one-to-clear
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			change_pend_q <= 24'h000000;
		else
			change_pend_q <= (change_pend_q &
				~(clr_stat ? hwdata[23:0] : 24'h000000)) | cn_hit; // R20
	end

	// Clock stopped: the stored level keeps its compare, so a change
	// made in sleep raises change_irq on the third edge once the clock returns.
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			change_irq <= 1'b0;
		else
			change_irq <= |((change_pend_q | cn_hit) & cn_en); // R15
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			weak_pullup_en <= 24'h000000;
		else
			weak_pullup_en <= {weak_pullup_enable_second_q[7:0],
				weak_pullup_enable_first_q}; // R17
	end

	////////////////////////////////////////////////////////////////////
	// Read data
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h00000000;
		unique case (adr_q)
			`SPIO_OFS_DIR:      rd_mux[15:0] = pin_direction_reg_q;
			`SPIO_OFS_HOLD:     rd_mux[15:0] = output_hold_reg_q; // R6
			`SPIO_OFS_LEVEL:    rd_mux[15:0] = level_view; // R6
			`SPIO_OFS_ODSEL:    rd_mux[15:0] = open_drain_sel_reg_q;
			`SPIO_OFS_ACFG_LO:  rd_mux[15:0] = analog_pin_cfg_low_q;
			`SPIO_OFS_ACFG_HI:  rd_mux[15:0] = analog_pin_cfg_high_q;
			`SPIO_OFS_CIE_1:    rd_mux[15:0] = change_irq_enable_first_q;
			`SPIO_OFS_CIE_2:    rd_mux[15:0] = change_irq_enable_second_q;
			`SPIO_OFS_CPU_1:    rd_mux[15:0] = weak_pullup_enable_first_q;
			`SPIO_OFS_CPU_2:    rd_mux[15:0] = weak_pullup_enable_second_q;
			`SPIO_OFS_CSTAT:    rd_mux[23:0] = change_pend_q;
			`SPIO_OFS_ACFG2_LO: rd_mux[15:0] = analog2_cfg_low_q;
			`SPIO_OFS_ACFG2_HI: rd_mux[15:0] = analog2_cfg_high_q;
			default:            rd_mux = 32'h00000000;
		endcase
	end

	// Loaded in the read wait state from the captured address
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			hrdata <= 32'h00000000;
		else if (take && !haddr_ph.hwrite)
			hrdata <= 32'h00000000;
		else if (rd_q)
			hrdata <= rd_mux;
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	property p_dir_reset;
		@(posedge ref_clk) $fell(sys_rst) |->
			pin_direction_reg_q == (`SPIO_DIR_RST & IMPL);
	endproperty
	a_dir_reset: assert property (p_dir_reset) // R5
		else $error("direction not input after reset");

	property p_periph_blocks;
		@(posedge ref_clk) disable iff (sys_rst)
			(|periph_owns) |=> ((pin_out ^ $past(periph.out_data)) &
			$past(periph_owns)) == 16'h0000;
	endproperty
	a_periph_blocks: assert property (p_periph_blocks) // R1
		else $error("port drove a peripheral-owned pin");

	property p_input_no_drive;
		@(posedge ref_clk) disable iff (sys_rst)
			1'b1 |=> (pin_oe & $past(pin_direction_reg_q) &
			~$past(periph_owns)) == 16'h0000;
	endproperty
	a_input_no_drive: assert property (p_input_no_drive) // R4
		else $error("input pin driven");

	property p_no_loop;
		@(posedge ref_clk) disable iff (sys_rst)
			1'b1 |=> (periph_in & $past(port_drive)) == 16'h0000;
	endproperty
	a_no_loop: assert property (p_no_loop) // R3
		else $error("port output looped into peripheral");

	property p_analog_zero;
		@(posedge ref_clk) disable iff (sys_rst)
			(rd_q && adr_q == `SPIO_OFS_LEVEL) |=>
			(hrdata[15:0] & $past(is_analog)) == 16'h0000;
	endproperty
	a_analog_zero: assert property (p_analog_zero) // R11
		else $error("analog pin reads high");

	sequence s_change;
		(cn_hit != 24'h000000);
	endsequence
	sequence s_raised;
		change_irq && (change_pend_q != 24'h000000);
	endsequence
	property p_change_irq;
		@(posedge ref_clk) disable iff (sys_rst)
			s_change |=> s_raised;
	endproperty
	a_change_irq: assert property (p_change_irq) // R14
		else $error("enabled change raised no request");

	property p_pend_hold;
		@(posedge ref_clk) disable iff (sys_rst)
			(change_pend_q[0] && !clr_stat) |=> change_pend_q[0];
	endproperty
	a_pend_hold: assert property (p_pend_hold) // R20
		else $error("pending flag lost");

	property p_od_high;
		@(posedge ref_clk) disable iff (sys_rst)
			1'b1 |=> (pin_oe & pin_out & $past(open_drain_sel_reg_q) &
			~$past(periph_owns)) == 16'h0000;
	endproperty
	a_od_high: assert property (p_od_high) // R8
		else $error("open-drain pin drove high");

endmodule // spio_port

//--- bench/spio_pad_model.sv
// Pad model: resolves each pin from port drive or outside drive
`timescale 1ns/100ps
module spio_pad_model (
	// Clock
	input  wire logic        ref_clk,
	// Port side
	input  wire logic [15:0] pin_out,
	input  wire logic [15:0] pin_oe,
	// Outside drive
	input  wire logic [15:0] ext_en,
	input  wire logic [15:0] ext_val,
	output logic      [15:0] pin_in
);
	logic [15:0] float_q = 16'h0000;
	// Undriven pads toggle so a stale level never passes as valid
	always_ff @(posedge ref_clk)
		float_q <= ~float_q;
	always_comb
		for (int i = 0; i < 16; i++)
			pin_in[i] = pin_oe[i] ? pin_out[i] :
				(ext_en[i] ? ext_val[i] : float_q[i]);
endmodule // spio_pad_model

//--- bench/shared_pin_io_port_tb.sv
// Self-checking bench for the shared-pin I/O port
`timescale 1ns/100ps
`include "spio_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
	$display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module shared_pin_io_port_tb;
	import spio_pkg::*;
	localparam logic [15:0] IMPL = 16'h7fff;
	typedef struct {logic [11:0] a; logic [31:0] d, e;} spio_row_t;
	logic ref_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hreadyout, hresp;
	logic change_irq;
	spio_addr_t haddr_ph = '0;
	spio_periph_t periph = '0;
	logic [31:0] hwdata = '0, hrdata, r;
	logic [15:0] pin_in, pin_out, pin_oe, periph_in;
	logic [15:0] ext_en = 16'hffff, ext_val = 16'h0000;
	logic [23:0] cn = '0, weak_pullup_en;
	int failures = 0, compares = 0, cycles = 0;
	spio_row_t rows[7] = '{
		'{`SPIO_OFS_DIR, 32'hffffffff, 32'h7fff},
		'{`SPIO_OFS_HOLD, 32'h0001a5a5, 32'h25a5},
		'{`SPIO_OFS_LEVEL, 32'h5a5a, 32'h7f00},
		'{`SPIO_OFS_CIE_2, 32'hffffffff, 32'hff},
		'{`SPIO_OFS_CPU_2, 32'hffffffff, 32'hff},
		'{`SPIO_OFS_ODSEL, 32'h0, 32'h0},
		'{12'h100, 32'hffffffff, 32'h0}};
	always #10 ref_clk = ~ref_clk;
	spio_port #(.IMPL(IMPL), .IN_ONLY(16'h0004)) dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst),
		.hsel(hsel), .haddr_ph(haddr_ph), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .periph(periph), .periph_in(periph_in),
		.change_notice_input(cn), .weak_pullup_en(weak_pullup_en),
		.change_irq(change_irq));
	spio_pad_model pads (.ref_clk(ref_clk), .pin_out(pin_out),
		.pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
		.pin_in(pin_in));
	////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		if (failures == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Address phase, then data phase; each held until hready is seen
	task automatic bus(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		hsel <= 1'b1;
		haddr_ph <= '{2'b10, w, 3'b010, {20'h0, a}};
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		haddr_ph.htrans <= 2'b00;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(r, e)
		`CHK(hresp, 1'b0)
	endtask
	// Waits for a rising request, or the full span for a quiet one
	task automatic wirq(input logic e);
		for (int n = 0; n < 6; n++) begin
			if (e && change_irq === 1'b1)
				break;
			@(posedge ref_clk);
		end
		`CHK(change_irq, e)
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			stop_test;
		end
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		ext_val <= 16'hffff;
		@(posedge ref_clk);
		`CHK(pin_oe, 16'h0)
		rd(`SPIO_OFS_DIR, {16'h0, IMPL});
		rd(`SPIO_OFS_LEVEL, 32'h7f00);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		rd(`SPIO_OFS_HOLD, 32'h5a5a);
		wr(`SPIO_OFS_ACFG_LO, 32'hffff);
		wr(`SPIO_OFS_ACFG2_LO, 32'hffff);
		wr(`SPIO_OFS_DIR, 32'hff00);
		wr(`SPIO_OFS_HOLD, 32'h00a5);
		ext_en <= 16'hff00;
		ext_val <= 16'hbc00;
		repeat (4) @(posedge ref_clk);
		`CHK(pin_oe, 16'h00ff)
		`CHK(pin_out[7:0], 8'ha5)
		`CHK(periph_in, 16'hbc00)
		rd(`SPIO_OFS_LEVEL, 32'h3ca5);
		wr(`SPIO_OFS_ODSEL, 32'h000f);
		repeat (2) @(posedge ref_clk);
		`CHK(pin_oe, 16'h00fa)
		wr(`SPIO_OFS_ODSEL, 32'h0);
		periph <= '{16'h0002, 16'h0006, 16'h0006};
		repeat (3) @(posedge ref_clk);
		`CHK(pin_out[1], 1'b1)
		`CHK(pin_out[2], 1'b1)
		rd(`SPIO_OFS_LEVEL, 32'h3ca7);
		periph.out_en <= 16'h0;
		repeat (3) @(posedge ref_clk);
		`CHK(pin_out[1], 1'b0)
		periph <= '0;
		// Analog pin kept as input so the converter sees the pad
		wr(`SPIO_OFS_DIR, 32'hff01);
		wr(`SPIO_OFS_ACFG2_LO, 32'hfffe);
		ext_en <= 16'hff01;
		ext_val <= 16'hbc01;
		repeat (3) @(posedge ref_clk);
		rd(`SPIO_OFS_LEVEL, 32'h3ca4);
		// Pull-ups only on pins left as inputs
		wr(`SPIO_OFS_CPU_1, 32'h0001);
		wr(`SPIO_OFS_CPU_2, 32'h0080);
		repeat (2) @(posedge ref_clk);
		`CHK(weak_pullup_en, 24'h800001)
		wr(`SPIO_OFS_CIE_1, 32'h0001);
		wr(`SPIO_OFS_CIE_2, 32'h0080);
		cn[1] <= 1'b1;
		wirq(1'b0);
		cn[0] <= 1'b1;
		wirq(1'b1);
		wr(`SPIO_OFS_CSTAT, 32'hffffff);
		wirq(1'b0);
		cn[23] <= 1'b1;
		wirq(1'b1);
		wr(`SPIO_OFS_CSTAT, 32'hffffff);
		wirq(1'b0);
		// Reset again in mid-run: port must fall back to all-input
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		`CHK(pin_oe, 16'h0000)
		rd(`SPIO_OFS_DIR, {16'h0, IMPL});
		stop_test;
	end
endmodule // shared_pin_io_port_tb
